// *** bench/swire_master_model.sv ***
// Bus master model: control words, read-data slots and clock-stop exit.
// Assumes the slave samples on rising link_clk_i; this model drives on falling.
`timescale 1ns/10ps
`default_nettype none

module swire_master_model (
    // Link clock
    input  wire logic                       link_clk_i,
    // Towards the slave
    output var swire_enum_pkg::ctrl_word_t  ctrl_o,
    output var swire_enum_pkg::rd_slot_t    slot_o,
    output var logic                        exit_o,
    // Answers from the slave
    input  wire logic                       cmd_hit_i,
    input  wire logic                       cmd_done_i,
    input  wire logic [7:0]                 rd_data_i,
    input  wire logic                       rd_bit_i,
    input  wire logic                       hard_reset_req_i
);
    initial begin
        ctrl_o = '0;
        slot_o = '0;
        exit_o = 1'b0;
    end

    // One control word, valid for one link cycle
    task automatic cmd(input logic wr, input logic [3:0] dev, input logic [7:0] adr, input logic [7:0] w,
                       output logic hit, output logic done, output logic [7:0] rd);
        if (wr && adr == swire_enum_pkg::NODE_NUM_OFS && w[3:0] > 4'hB) w[3:0] = 4'hB;
        @(negedge link_clk_i);
        ctrl_o = {1'b1, wr, dev, adr, w};
        @(posedge link_clk_i);
        hit = cmd_hit_i;
        @(negedge link_clk_i);
        ctrl_o = {1'b0, ~ctrl_o[20:0]};
        done = cmd_done_i;
        rd = rd_data_i;
    endtask

    // Eight read slots, MSB first, clash flagged at slot k
    task automatic read_bits(input int k, output logic [7:0] bits);
        for (int i = 7; i >= 0; i--) begin
            @(negedge link_clk_i);
            slot_o = {1'b1, i[2:0], i == k};
            @(negedge link_clk_i);
            slot_o = {1'b0, ~i[2:0], 1'b0};
            bits[i] = rd_bit_i;
        end
    endtask

    // Leave clock-stop and count hard reset pulses
    task automatic exit_pulse(output int pulses);
        pulses = 0;
        @(negedge link_clk_i);
        exit_o = 1'b1;
        repeat (6) begin
            @(negedge link_clk_i);
            exit_o = 1'b0;
            if (hard_reset_req_i === 1'b1) pulses++;
        end
    endtask
endmodule // swire_master_model
`default_nettype wire

// *** bench/tb_soundwire_slave_enum_ctrl.sv ***
// Self-checking bench for the slave enumeration and clock-stop control block.
// Assumes the bus master model in swire_master_model.sv drives the link side.
`timescale 1ns/10ps
`default_nettype none

module tb_soundwire_slave_enum_ctrl;
    localparam logic [7:0] MAKER = 8'hA7; // Arbitrary value
    logic sys_clk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1;
    logic mic_short_button_i = 1'b0, hp_plug_i = 1'b0, strap_pin_hi_i, strap_pin_lo_i;
    logic shutdown_done_i = 1'b0, wake_ack_i = 1'b0, clock_stop_exit_i;
    swire_enum_pkg::ctrl_word_t ctrl_i;
    swire_enum_pkg::rd_slot_t   slot_i;
    logic       cmd_hit_o, cmd_done_o, rd_bit_o, enum_on_o, stop_pending_o;
    logic       hard_reset_req_o, prepare_o, wake_o, h, d;
    logic [7:0] rd_data_o, r, b;
    logic [3:0] node_m = 4'h0, dev;
    logic [1:0] grp_m = 2'h0;
    int         miscompares = 0, num_checks = 0, n, p;
    int         ks[3] = '{-1, 7, 3};

    always #4 sys_clk_i = ~sys_clk_i;
    initial #3.1 forever #7.5 link_clk_i = ~link_clk_i;

    soundwire_slave_enum_ctrl #(.MAKER_CODE(MAKER)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .ctrl_i(ctrl_i), .slot_i(slot_i),
        .clock_stop_exit_i(clock_stop_exit_i), .cmd_hit_o(cmd_hit_o), .cmd_done_o(cmd_done_o),
        .rd_data_o(rd_data_o), .rd_bit_o(rd_bit_o), .enum_on_o(enum_on_o), .stop_pending_o(stop_pending_o),
        .hard_reset_req_o(hard_reset_req_o), .mic_short_button_i(mic_short_button_i), .hp_plug_i(hp_plug_i),
        .strap_pin_hi_i(strap_pin_hi_i), .strap_pin_lo_i(strap_pin_lo_i), .shutdown_done_i(shutdown_done_i),
        .wake_ack_i(wake_ack_i), .prepare_o(prepare_o), .wake_o(wake_o));

    swire_master_model i_master (
        .link_clk_i(link_clk_i), .ctrl_o(ctrl_i), .slot_o(slot_i), .exit_o(clock_stop_exit_i),
        .cmd_hit_i(cmd_hit_o), .cmd_done_i(cmd_done_o), .rd_data_i(rd_data_o), .rd_bit_i(rd_bit_o),
        .hard_reset_req_i(hard_reset_req_o));

    function automatic logic [7:0] id0_exp();
        return {4'h1, 2'b00, strap_pin_hi_i, strap_pin_lo_i};
    endfunction

    function automatic logic hit_exp(input logic [3:0] a);
        return (a == node_m) || (grp_m == 2'h1 && a == 4'hC) || (grp_m == 2'h2 && a == 4'hD);
    endfunction

    function automatic logic [7:0] clash_exp(input logic [7:0] v, input int k);
        for (int i = 0; i < 8; i++) if (i <= k && k >= 0) v[i] = 1'b0;
        return v;
    endfunction

    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk_flag(input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bounded(input int lim);
        if (n >= lim) begin
            miscompares++;
            finish_test();
        end
    endtask

    task automatic wr45(input logic [7:0] v);
        i_master.cmd(1'b1, node_m, swire_enum_pkg::WAKE_HALT_OFS, v, h, d, r);
        repeat (12) @(negedge sys_clk_i);
    endtask

    initial begin
        #400us;
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(88711));
        {strap_pin_hi_i, strap_pin_lo_i} = 2'($urandom);
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge link_clk_i);
        chk_flag(1'b1, stop_pending_o);
        // Enumeration off
        i_master.cmd(1'b0, 4'h0, swire_enum_pkg::ENUM_ID1_OFS, 8'h00, h, d, r);
        chk_byte(8'h00, r);
        i_master.cmd(1'b1, 4'h0, swire_enum_pkg::NODE_NUM_OFS, 8'h05, h, d, r);
        chk_flag(1'b0, d);
        i_master.cmd(1'b0, 4'h5, swire_enum_pkg::WAKE_HALT_OFS, 8'h00, h, d, r);
        chk_flag(1'b0, h);
        $display("test enum_off done");
        // Node number and alias groups
        i_master.cmd(1'b0, 4'h0, swire_enum_pkg::ENUM_ID0_OFS, 8'h00, h, d, r);
        chk_flag(1'b1, enum_on_o);
        for (int g = 0; g < 4; g++) begin
            dev = 4'($urandom_range(11));
            i_master.cmd(1'b1, node_m, swire_enum_pkg::NODE_NUM_OFS, {2'($urandom), g[1:0], dev}, h, d, r);
            chk_flag(1'b1, d);
            {grp_m, node_m} = {g[1:0], dev};
            i_master.cmd(1'b0, node_m, swire_enum_pkg::NODE_NUM_OFS, 8'h00, h, d, r);
            chk_byte({2'b00, grp_m, node_m}, r);
            for (int j = 0; j < 6; j++) begin
                dev = (j < 2) ? 4'hC + 4'(j) : 4'($urandom);
                i_master.cmd(1'b0, dev, swire_enum_pkg::WAKE_HALT_OFS, 8'h00, h, d, r);
                chk_flag(hit_exp(dev), h);
            end
        end
        $display("test node_alias done");
        // ID reads with no clash, a clash at the first slot and a clash in mid-read
        foreach (ks[i]) begin
            i_master.cmd(1'b0, node_m, swire_enum_pkg::ENUM_ID0_OFS, 8'h00, h, d, r);
            chk_byte(id0_exp(), r);
            i_master.read_bits(ks[i], b);
            chk_byte(clash_exp(id0_exp(), ks[i]), b);
            chk_flag(ks[i] < 0, enum_on_o);
            i_master.cmd(1'b0, node_m, swire_enum_pkg::ENUM_ID1_OFS, 8'h00, h, d, r);
            chk_byte((ks[i] < 0) ? MAKER : 8'h00, r);
        end
        $display("test id_clash done");
        // Control bits, reserved bits and context loss
        wr45(8'hFF);
        i_master.cmd(1'b0, node_m, swire_enum_pkg::WAKE_HALT_OFS, 8'h00, h, d, r);
        chk_byte(8'h0D, r);
        for (int c = 1; c >= 0; c--) begin
            wr45({5'h00, c[0], 2'b00});
            i_master.exit_pulse(p);
            chk_byte(8'(c), p[7:0]);
        end
        $display("test ctx_loss done");
        // Prepare and shutdown handshake
        wr45(8'h01);
        for (n = 0; n < 20 && prepare_o !== 1'b1; n++) @(negedge sys_clk_i);
        chk_flag(1'b1, prepare_o);
        repeat (10) @(negedge sys_clk_i);
        chk_flag(1'b1, stop_pending_o);
        shutdown_done_i = 1'b1;
        for (n = 0; n < 30 && stop_pending_o !== 1'b0; n++) @(negedge sys_clk_i);
        bounded(30);
        wr45(8'h00);
        shutdown_done_i = 1'b0;
        for (n = 0; n < 30 && stop_pending_o !== 1'b1; n++) @(negedge sys_clk_i);
        chk_flag(1'b1, stop_pending_o);
        $display("test prepare done");
        // Wake from button and plug events
        wr45(8'h08);
        for (int e = 0; e < 4; e++) begin
            if (e == 3) wr45(8'h00);
            @(negedge sys_clk_i);
            if (e == 0) mic_short_button_i = 1'b1;
            else hp_plug_i = ~hp_plug_i;
            for (n = 0; n < 12 && wake_o !== 1'b1; n++) @(negedge sys_clk_i);
            chk_flag(e < 3, wake_o);
            wake_ack_i = 1'b1;
            mic_short_button_i = 1'b0;
            @(negedge sys_clk_i);
            wake_ack_i = 1'b0;
            repeat (4) @(negedge sys_clk_i);
            chk_flag(1'b0, wake_o);
        end
        $display("test wake done");
        finish_test();
    end
endmodule // tb_soundwire_slave_enum_ctrl
`default_nettype wire

// *** hw/soundwire_slave_enum_ctrl.sv ***
// Control-port registers, address match and enumeration state for the slave.
// Assumes a framer on link_clk_i delivering decoded control words and read slots,
// and wake sources and shutdown handshake on sys_clk_i.
//
// Summary of operation
// R1: Wake enable bit 3 lets button or headphone plug/unplug raise asynchronous wake.
// R2: Mode bit 2 set allows context loss; leaving clock-stop then requests hard reset.
// R3: Master sets prepare bit 0; device then starts preparing for clock-stop.
// R4: Group field 5:4: 01 answers alias 12, 10 answers alias 13, else none.
// R5: Commands are ours only when address matches node number or active alias.
// R6: Master programs node numbers 0 to 11 only; 12 to 15 reserved.
// R7: Node number writes are ignored and not completed while enumeration is off.
// R8: Reading the first ID register at 0x50 turns enumeration on.
// R9: ID registers read their values with enumeration on; with it off 0x51 reads zero and 0x50 still reads its value.
// R10: Bus clash while driving ID data drops enumeration and zeroes remaining bits.
// R11: First ID register bits 7:4 report specification revision, 0001 for 1.0.
// R12: First ID bits 3:0 are 00 and the two straps latched at reset.
// R13: ID register 0x51 returns the maker code upper byte while enumeration on.
// R14: Clock-stop pending stays set until shutdown completes, then clears.
// R15: Master waits for pending to clear after prepare before stopping clock.
// R16: Reserved control bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none

module soundwire_slave_enum_ctrl #(
    parameter logic [3:0] SPEC_REV   = swire_enum_pkg::SPEC_REV_V10,
    parameter logic [7:0] MAKER_CODE = 8'h5A  // Arbitrary value
) (
    // System clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    // Link clock
    input  wire logic                        link_clk_i,
    // Control words and read slots from the framer
    input  wire swire_enum_pkg::ctrl_word_t  ctrl_i,
    input  wire swire_enum_pkg::rd_slot_t    slot_i,
    input  wire logic                        clock_stop_exit_i,
    // Answers to the framer
    output logic                             cmd_hit_o,
    output logic                             cmd_done_o,
    output logic [7:0]                       rd_data_o,
    output logic                             rd_bit_o,
    output logic                             enum_on_o,
    output logic                             stop_pending_o,
    output logic                             hard_reset_req_o,
    // Wake sources and straps
    input  wire logic                        mic_short_button_i,
    input  wire logic                        hp_plug_i,
    input  wire logic                        strap_pin_hi_i,
    input  wire logic                        strap_pin_lo_i,
    // Shutdown handshake and wake
    input  wire logic                        shutdown_done_i,
    input  wire logic                        wake_ack_i,
    output logic                             prepare_o,
    output logic                             wake_o
);

    // ---------------- System domain ----------------
    logic [5:0] sys_meta;
    logic [5:0] sys_sync;
    logic       btn_prev;
    logic       plug_prev;
    logic [1:0] strap_latched;
    logic       strap_taken;
    logic       pending_sys;
    logic       wake_req;

    // Pin and link-level synchronisers
    logic       prepare_link;
    logic [7:0] wake_halt;
    always_ff @(posedge sys_clk_i) begin
        sys_meta <= {strap_pin_hi_i, strap_pin_lo_i, mic_short_button_i, hp_plug_i,
                     wake_halt[swire_enum_pkg::WAKE_EN_BIT], prepare_link};
        sys_sync <= sys_meta;
    end

    // Straps caught once after reset release
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            strap_taken   <= 1'b0;
            strap_latched <= 2'h0;
        end else if (!strap_taken) begin
            strap_taken   <= 1'b1;
            strap_latched <= sys_sync[5:4]; // R12
        end
    end

    // Clock-stop preparation
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pending_sys <= 1'b1;
        end else if (!sys_sync[0]) begin
            pending_sys <= 1'b1;
        end else if (shutdown_done_i) begin
            pending_sys <= 1'b0; // R14
        end
    end

    // Wake from plug, unplug or button
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            btn_prev  <= 1'b0;
            plug_prev <= 1'b0;
            wake_req  <= 1'b0;
        end else begin
            btn_prev  <= sys_sync[3];
            plug_prev <= sys_sync[2];
            if (sys_sync[1] && ((sys_sync[3] && !btn_prev) || (sys_sync[2] != plug_prev))) begin
                wake_req <= 1'b1; // R1
            end else if (wake_ack_i || !sys_sync[1]) begin
                wake_req <= 1'b0; // R1
            end
        end
    end

    assign prepare_o = sys_sync[0]; // R3
    assign wake_o    = wake_req;

    // ---------------- Link domain ----------------
    logic                        link_rst_meta;
    logic                        link_rst;
    logic [2:0]                  link_meta;
    logic [2:0]                  link_sync;
    logic [5:0]                  node_num;
    swire_enum_pkg::enum_state_t enum_state;
    logic                        id_read;
    logic                        clashed;
    logic                        hit;
    logic                        id_addr;
    logic                        node_wr;
    logic [7:0]                  id0_val;
    logic [7:0]                  next_rd_data;
    logic                        next_done;

    // Reset and level crossings into the link domain
    always_ff @(posedge link_clk_i) begin
        link_rst_meta <= rst_i;
        link_rst      <= link_rst_meta;
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            link_meta <= 3'h0;
            link_sync <= 3'h0;
        end else begin
            link_meta <= {strap_latched, pending_sys};
            link_sync <= link_meta;
        end
    end

    // Address match on node number or alias
    always_comb begin
        hit = (ctrl_i.dev_addr == node_num[swire_enum_pkg::NODE_HI:swire_enum_pkg::NODE_LO]); // R5
        case (node_num[swire_enum_pkg::GROUP_HI:swire_enum_pkg::GROUP_LO])
            swire_enum_pkg::GROUP_ALIAS12: hit = hit || (ctrl_i.dev_addr == swire_enum_pkg::ALIAS12_ADDR); // R4
            swire_enum_pkg::GROUP_ALIAS13: hit = hit || (ctrl_i.dev_addr == swire_enum_pkg::ALIAS13_ADDR); // R4
            default:                       hit = hit;
        endcase
    end

    assign id_addr = (ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID0_OFS) ||
                     (ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID1_OFS);
    assign node_wr = ctrl_i.valid && hit && ctrl_i.write &&
                     (ctrl_i.reg_addr == swire_enum_pkg::NODE_NUM_OFS);
    assign id0_val = {SPEC_REV, swire_enum_pkg::INSTANCE_UPPER, link_sync[2:1]}; // R11 R12

    // Read data and completion
    always_comb begin
        next_rd_data = 8'h00;
        next_done    = ctrl_i.valid && hit;
        case (ctrl_i.reg_addr)
            swire_enum_pkg::WAKE_HALT_OFS: next_rd_data = wake_halt & swire_enum_pkg::WAKE_HALT_MASK; // R16
            swire_enum_pkg::NODE_NUM_OFS: begin
                next_rd_data = {2'h0, node_num}; // R16
                if (ctrl_i.write && enum_state == swire_enum_pkg::ENUM_OFF) begin
                    next_done = 1'b0; // R7
                end
            end
            swire_enum_pkg::ENUM_ID0_OFS: next_rd_data = id0_val; // R9
            swire_enum_pkg::ENUM_ID1_OFS: next_rd_data = MAKER_CODE; // R13
            default:                      next_rd_data = 8'h00;
        endcase
        if (id_addr && enum_state == swire_enum_pkg::ENUM_OFF &&
            !(ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID0_OFS && !ctrl_i.write)) begin
            next_rd_data = 8'h00; // R9
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            cmd_done_o <= 1'b0;
            rd_data_o  <= 8'h00;
        end else begin
            cmd_done_o <= next_done;
            if (ctrl_i.valid && hit && !ctrl_i.write) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    assign cmd_hit_o = ctrl_i.valid && hit;

    // System control register
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            wake_halt <= swire_enum_pkg::WAKE_HALT_RST;
        end else if (ctrl_i.valid && hit && ctrl_i.write &&
                     ctrl_i.reg_addr == swire_enum_pkg::WAKE_HALT_OFS) begin
            wake_halt <= ctrl_i.wdata & swire_enum_pkg::WAKE_HALT_MASK; // R16
        end
    end

    assign prepare_link = wake_halt[swire_enum_pkg::PREPARE_BIT]; // R3

    // Node number register
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            node_num <= swire_enum_pkg::NODE_NUM_RST;
        end else if (node_wr && enum_state == swire_enum_pkg::ENUM_ON) begin
            node_num <= ctrl_i.wdata[5:0]; // R7
        end
    end

    // Enumeration state
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            enum_state <= swire_enum_pkg::ENUM_OFF;
        end else begin
            case (enum_state)
                swire_enum_pkg::ENUM_OFF: begin
                    if (ctrl_i.valid && hit && !ctrl_i.write &&
                        ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID0_OFS) begin
                        enum_state <= swire_enum_pkg::ENUM_ON; // R8
                    end
                end
                swire_enum_pkg::ENUM_ON: begin
                    if (id_read && slot_i.strobe && slot_i.clash) begin
                        enum_state <= swire_enum_pkg::ENUM_OFF; // R10
                    end
                end
                default: enum_state <= swire_enum_pkg::ENUM_OFF;
            endcase
        end
    end

    assign enum_on_o = (enum_state == swire_enum_pkg::ENUM_ON);

    // Serial drive of read data with clash cut-off
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            id_read  <= 1'b0;
            clashed  <= 1'b0;
            rd_bit_o <= 1'b0;
        end else begin
            if (ctrl_i.valid) begin
                id_read <= hit && !ctrl_i.write && id_addr;
                clashed <= 1'b0;
            end else if (id_read && slot_i.strobe && slot_i.clash) begin
                clashed <= 1'b1; // R10
            end
            if (slot_i.strobe) begin
                rd_bit_o <= rd_data_o[slot_i.index] && !clashed && !(id_read && slot_i.clash); // R10
            end
        end
    end

    // Context loss handling on clock-stop exit
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            hard_reset_req_o <= 1'b0;
        end else begin
            hard_reset_req_o <= clock_stop_exit_i && wake_halt[swire_enum_pkg::CTX_LOSS_BIT]; // R2
        end
    end

    assign stop_pending_o = link_sync[0]; // R14

    // ---------------- Assertions ----------------
    sequence s_id0_read;
        ctrl_i.valid && hit && !ctrl_i.write && ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID0_OFS;
    endsequence

    sequence s_clash_on_id;
        id_read && slot_i.strobe && slot_i.clash && !ctrl_i.valid;
    endsequence

    property p_enum_on_read;
        @(posedge link_clk_i) disable iff (link_rst)
        s_id0_read |=> enum_on_o;
    endproperty
    a_enum_on_read: assert property (p_enum_on_read) else $error("enum not on after ID0 read"); // R8

    property p_clash_drop;
        @(posedge link_clk_i) disable iff (link_rst)
        s_clash_on_id |=> !enum_on_o && clashed;
    endproperty
    a_clash_drop: assert property (p_clash_drop) else $error("clash did not drop enumeration"); // R10

    property p_clash_zero;
        @(posedge link_clk_i) disable iff (link_rst)
        s_clash_on_id ##1 !ctrl_i.valid ##1 (slot_i.strobe && !ctrl_i.valid) |=> !rd_bit_o;
    endproperty
    a_clash_zero: assert property (p_clash_zero) else $error("bit driven after clash"); // R10

    property p_node_locked;
        @(posedge link_clk_i) disable iff (link_rst)
        node_wr && !enum_on_o |=> $stable(node_num) && !cmd_done_o;
    endproperty
    a_node_locked: assert property (p_node_locked) else $error("node written while enum off"); // R7

    property p_id_zero_off;
        @(posedge link_clk_i) disable iff (link_rst)
        ctrl_i.valid && hit && !ctrl_i.write && ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID1_OFS && !enum_on_o
        |=> rd_data_o == 8'h00;
    endproperty
    a_id_zero_off: assert property (p_id_zero_off) else $error("ID1 returned data with enum off"); // R9

    property p_maker_on;
        @(posedge link_clk_i) disable iff (link_rst)
        ctrl_i.valid && hit && !ctrl_i.write && ctrl_i.reg_addr == swire_enum_pkg::ENUM_ID1_OFS && enum_on_o
        |=> rd_data_o == MAKER_CODE;
    endproperty
    a_maker_on: assert property (p_maker_on) else $error("maker code wrong"); // R13

    property p_alias12;
        @(posedge link_clk_i) disable iff (link_rst)
        ctrl_i.valid && node_num[5:4] == swire_enum_pkg::GROUP_ALIAS12 &&
        ctrl_i.dev_addr == swire_enum_pkg::ALIAS12_ADDR |-> cmd_hit_o;
    endproperty
    a_alias12: assert property (p_alias12) else $error("alias 12 not accepted"); // R4

    property p_foreign;
        @(posedge link_clk_i) disable iff (link_rst)
        ctrl_i.valid && ctrl_i.dev_addr != node_num[3:0] && node_num[5:4] == swire_enum_pkg::GROUP_NONE
        |-> !cmd_hit_o;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign command accepted"); // R5

    property p_reserved_zero;
        @(posedge link_clk_i) disable iff (link_rst)
        ctrl_i.valid && hit && !ctrl_i.write && ctrl_i.reg_addr == swire_enum_pkg::WAKE_HALT_OFS
        |=> (rd_data_o & ~swire_enum_pkg::WAKE_HALT_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // R16

    property p_hard_reset;
        @(posedge link_clk_i) disable iff (link_rst)
        clock_stop_exit_i |=> hard_reset_req_o == $past(wake_halt[swire_enum_pkg::CTX_LOSS_BIT]);
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("hard reset request mismatch"); // R2

    property p_pending_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        !sys_sync[0] |=> pending_sys;
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("pending cleared without prepare"); // R14

    property p_wake_gate;
        @(posedge sys_clk_i) disable iff (rst_i)
        !sys_sync[1] |=> !wake_o;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake raised while disabled"); // R1

endmodule // soundwire_slave_enum_ctrl

`default_nettype wire

// *** hw/swire_enum_pkg.sv ***
// Shared constants and carriers for the slave control-port enumeration block.
// Assumes byte-wide registers addressed by their offset from the port base.
package swire_enum_pkg;

    // Register offsets
    localparam logic [7:0] WAKE_HALT_OFS   = 8'h45;
    localparam logic [7:0] NODE_NUM_OFS    = 8'h46;
    localparam logic [7:0] ENUM_ID0_OFS    = 8'h50;
    localparam logic [7:0] ENUM_ID1_OFS    = 8'h51;

    // Wake/halt control field positions
    localparam int WAKE_EN_BIT     = 3;
    localparam int CTX_LOSS_BIT    = 2;
    localparam int PREPARE_BIT     = 0;
    localparam logic [7:0] WAKE_HALT_RST  = 8'h00;
    localparam logic [7:0] WAKE_HALT_MASK = 8'h0D;

    // Node number field positions
    localparam int GROUP_HI        = 5;
    localparam int GROUP_LO        = 4;
    localparam int NODE_HI         = 3;
    localparam int NODE_LO         = 0;
    localparam logic [5:0] NODE_NUM_RST   = 6'h00;

    // Alias group decode
    localparam logic [1:0] GROUP_NONE     = 2'h0;
    localparam logic [1:0] GROUP_ALIAS12  = 2'h1;
    localparam logic [1:0] GROUP_ALIAS13  = 2'h2;
    localparam logic [3:0] ALIAS12_ADDR   = 4'hC;
    localparam logic [3:0] ALIAS13_ADDR   = 4'hD;

    // Identification fields
    localparam logic [3:0] SPEC_REV_V10   = 4'h1;
    localparam logic [1:0] INSTANCE_UPPER = 2'h0;

    // Enumeration state
    typedef enum logic [0:0] {
        ENUM_OFF = 1'b0,
        ENUM_ON  = 1'b1
    } enum_state_t;

    // Control word from the link framer
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] dev_addr;
        logic [7:0] reg_addr;
        logic [7:0] wdata;
    } ctrl_word_t;

    // Serial read-data slot from the link framer
    typedef struct packed {
        logic       strobe;
        logic [2:0] index;
        logic       clash;
    } rd_slot_t;

endpackage
